// ===== core/flash_pkg.sv
// constants, types and state layout for the flash protection sequencer
package flash_pkg;

  // ------------------------------------------------------------
  // clock and operation times
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned T_WRITE_US    = 30;
  localparam int unsigned T_READ_NS     = 100;
  localparam int unsigned T_PAGE_MS     = 20;
  localparam int unsigned T_PW_MS       = 21;
  localparam int unsigned T_ALL_MS      = 200;

  // least times, rounded up to whole cycles
  localparam logic [24:0] WRITE_CYC = 25'((T_WRITE_US * 1000
    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [24:0] READ_CYC  = 25'((T_READ_NS
    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [24:0] ONE_CYC   = 25'h0000001;

  // ------------------------------------------------------------
  // sfr addresses
  // ------------------------------------------------------------
  localparam logic [7:0] A_CMD     = 8'hb9;
  localparam logic [7:0] A_KEY     = 8'hba;
  localparam logic [7:0] A_PKEY    = 8'hbb;
  localparam logic [7:0] A_DATA    = 8'hbc;
  localparam logic [7:0] A_PB0     = 8'hbd;
  localparam logic [7:0] A_PB1     = 8'hbe;
  localparam logic [7:0] A_PRD     = 8'hbf;
  localparam logic [7:0] A_ADDR_LO = 8'hc6;
  localparam logic [7:0] A_ADDR_HI = 8'hc7;

  // ------------------------------------------------------------
  // codes and values
  // ------------------------------------------------------------
  localparam logic [7:0] ACCESS_KEY     = 8'h3b;
  localparam logic [7:0] EMU_LOAD       = 8'h49;
  localparam logic [7:0] EMU_STORE      = 8'h46;
  localparam logic [7:0] CMD_WRITE      = 8'h01;
  localparam logic [7:0] CMD_PAGE       = 8'h02;
  localparam logic [7:0] CMD_ALL        = 8'h03;
  localparam logic [7:0] CMD_READ       = 8'h04;
  localparam logic [7:0] CMD_PAGE_WRITE = 8'h05;
  localparam logic [7:0] CMD_PROT       = 8'h08;
  localparam logic [7:0] STAT_OK        = 8'h00;
  localparam logic [7:0] STAT_FAIL      = 8'h01;
  localparam logic [7:0] REG_RST        = 8'h00;
  localparam logic [7:0] PROT_ERASED    = 8'hff;
  localparam logic [13:0] PROT_BASE     = 14'h3ffa;
  localparam logic [2:0] PROT_LAST      = 3'h5;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    FL_NONE = 3'h0, FL_READ = 3'h1, FL_WRITE = 3'h2,
    FL_PAGE = 3'h3, FL_ALL = 3'h4, FL_PAGE_WRITE = 3'h5
  } fl_op_t;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00, ST_IDLE = 2'b01, ST_RUN = 2'b10
  } state_t;

  typedef enum logic [1:0] {
    SQ_LOAD = 2'b00, SQ_CMD = 2'b01, SQ_PROT = 2'b10
  } seq_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [7:0] data;
  } emu_cmd_t;

  typedef struct packed {
    logic        start;
    fl_op_t      op;
    logic [13:0] addr;
    logic [7:0]  wdata;
    logic [31:0] keep;
  } fl_req_t;

  typedef struct packed {
    state_t         st;
    seq_t           seq;
    logic [24:0]    cnt;
    logic [2:0]     idx;
    logic           strap_s1;
    logic           strap_s2;
    logic           dl;
    logic [7:0]     stat;
    logic [7:0]     edata;
    logic [7:0]     addr_lo;
    logic [7:0]     addr_hi;
    logic [7:0]     key;
    logic [7:0]     pkey;
    logic [7:0]     pb0;
    logic [7:0]     pb1;
    logic [7:0]     prd;
    logic [7:0]     scratch;
    logic [5:0][7:0] pb;
    fl_req_t        req;
    logic [7:0]     rdata;
  } ctl_t;

  localparam ctl_t CTL_RST = '0;

endpackage

// ===== core/flash_protection_and_download.sv
// flash command sequencer with page protection and download-mode access
`timescale 1ns/1ps
`default_nettype none

module flash_protection_and_download #(
  parameter int unsigned PAGE_CYC = flash_pkg::T_PAGE_MS * 1000000
                                    / flash_pkg::CLK_PERIOD_NS,
  parameter int unsigned PW_CYC   = flash_pkg::T_PW_MS * 1000000
                                    / flash_pkg::CLK_PERIOD_NS,
  parameter int unsigned ALL_CYC  = flash_pkg::T_ALL_MS * 1000000
                                    / flash_pkg::CLK_PERIOD_NS
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  input  wire flash_pkg::sfr_req_t i_sfr,
  output logic [7:0]              o_sfr_rdata,
  input  wire flash_pkg::emu_cmd_t i_emu,
  input  wire logic               i_serial_download_strap_n,
  input  wire logic [7:0]         i_fl_rdata,
  output flash_pkg::fl_req_t      o_fl_req,
  output logic                    o_core_hold,
  output logic                    o_download_mode,
  output logic                    o_prot_active
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  flash_pkg::ctl_t q;        // registered state
  flash_pkg::ctl_t n;        // next state

  // ------------------------------------------------------------
  // protection decode
  // ------------------------------------------------------------
  logic            prot_act; // scheme armed by last page
  logic [31:0]     we_mask;  // one marks a write-protected page
  logic [7:0]      rd_mask;  // one marks a read-protected group
  logic [4:0]      page;     // page of the current address
  logic            pg_we;    // current page write-protected
  logic            pg_rd;    // current page read-protected
  logic [7:0]      key_src;  // key byte to program
  logic [5:0][7:0] prot_src; // bytes for the protection command
  logic [2:0]      idx_nx;   // next protection byte
  logic            pkey_ok;  // protection key satisfied

  // the scheme means nothing unless the last page is both read
  // and write protected, so a half-set map stays inert
  assign prot_act = ~q.pb[5][7] & ~q.pb[1][7];
  // a cleared bit protects; an erased byte of ones protects nothing
  assign we_mask = prot_act ? ~{q.pb[5], q.pb[4], q.pb[3], q.pb[2]}
                            : 32'h00000000;
  assign rd_mask = prot_act ? ~q.pb[1] : 8'h00;
  assign page    = q.addr_hi[5:1];
  assign pg_we   = we_mask[page];
  // the protection bytes sit in the last page, so arming it also
  // hides them from byte reads
  assign pg_rd   = rd_mask[page[4:2]];

  // once a key differs from erased the protection command can never change it
  assign key_src = (q.pb[0] == flash_pkg::PROT_ERASED) ? q.pkey
                                                        : q.pb[0];
  assign pkey_ok = (q.pb[0] == flash_pkg::PROT_ERASED) ||
                   (q.pkey == q.pb[0]);
  assign prot_src = {q.addr_hi, q.addr_lo, q.pb1, q.pb0, q.prd,
                     key_src};
  assign idx_nx  = 3'(q.idx + 3'h1);

  // ------------------------------------------------------------
  // sfr write path: core or emulator store
  // ------------------------------------------------------------
  logic       emu_ok;   // emulator command accepted
  logic       emu_st;   // emulator store this cycle
  logic       wr;       // merged write strobe
  logic [7:0] waddr;    // merged write address
  logic [7:0] wdat;     // merged write data
  logic       cmd_wr;   // write to the command sfr
  logic [13:0] fl_addr; // byte address in the array

  // the kernel is the only thing running in download mode, so the
  // emulator takes the port ahead of the core
  assign emu_ok = i_emu.valid & q.dl;
  assign emu_st = emu_ok & (i_emu.code == flash_pkg::EMU_STORE);
  assign wr     = emu_st | i_sfr.wr;
  assign waddr  = emu_st ? i_emu.data : i_sfr.addr;
  assign wdat   = emu_st ? q.scratch : i_sfr.wdata;
  assign cmd_wr = wr & (waddr == flash_pkg::A_CMD);
  assign fl_addr = {q.addr_hi[5:0], q.addr_lo};

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    n = q;
    n.req.start = 1'b0;
    // two-stage synchroniser for the strap pin
    // the first flop may be metastable; only the second is read
    n.strap_s1 = i_serial_download_strap_n;
    n.strap_s2 = q.strap_s1;

    // scratch load from the emulator
    if (emu_ok && (i_emu.code == flash_pkg::EMU_LOAD)) begin
      n.scratch = i_emu.data;
    end

    // register reads answer one cycle after the strobe
    if (i_sfr.rd) begin
      case (i_sfr.addr)
        flash_pkg::A_CMD:     n.rdata = q.stat;
        flash_pkg::A_DATA:    n.rdata = q.edata;
        flash_pkg::A_ADDR_LO: n.rdata = q.addr_lo;
        flash_pkg::A_ADDR_HI: n.rdata = q.addr_hi;
        flash_pkg::A_PKEY:    n.rdata = q.pkey;
        flash_pkg::A_PB0:     n.rdata = q.pb0;
        flash_pkg::A_PB1:     n.rdata = q.pb1;
        flash_pkg::A_PRD:     n.rdata = q.prd;
        default:              n.rdata = flash_pkg::REG_RST;
      endcase
    end

    // plain register writes; the key reads back as zero
    if (wr) begin
      case (waddr)
        flash_pkg::A_DATA:    n.edata   = wdat;
        flash_pkg::A_ADDR_LO: n.addr_lo = wdat;
        flash_pkg::A_ADDR_HI: n.addr_hi = wdat;
        flash_pkg::A_KEY:     n.key     = wdat;
        flash_pkg::A_PKEY:    n.pkey    = wdat;
        flash_pkg::A_PB0:     n.pb0     = wdat;
        flash_pkg::A_PB1:     n.pb1     = wdat;
        flash_pkg::A_PRD:     n.prd     = wdat;
        default:              n.key     = q.key;
      endcase
    end

    case (q.st)
      // read one protection byte from the array
      flash_pkg::ST_BOOT: begin
        n.req.start = 1'b1;
        n.req.op    = flash_pkg::FL_READ;
        n.req.addr  = 14'(flash_pkg::PROT_BASE + 14'(q.idx));
        n.req.wdata = flash_pkg::REG_RST;
        n.req.keep  = 32'h00000000;
        n.cnt       = flash_pkg::READ_CYC;
        n.seq       = flash_pkg::SQ_LOAD;
        n.st        = flash_pkg::ST_RUN;
      end

      // waiting for a command; command writes while busy are lost
      flash_pkg::ST_IDLE: begin
        if (cmd_wr) begin
          n.key       = flash_pkg::REG_RST;
          n.seq       = flash_pkg::SQ_CMD;
          n.st        = flash_pkg::ST_RUN;
          n.stat      = flash_pkg::STAT_OK;
          n.req.start = 1'b1;
          n.req.addr  = fl_addr;
          n.req.wdata = q.edata;
          n.req.keep  = 32'h00000000;
          n.req.op    = flash_pkg::FL_NONE;
          n.cnt       = flash_pkg::ONE_CYC;
          // a missing key refuses every command
          if (q.key != flash_pkg::ACCESS_KEY) begin
            n.req.start = 1'b0;
            n.stat      = flash_pkg::STAT_FAIL;
          end else begin
            case (wdat)
              flash_pkg::CMD_WRITE: begin
                n.req.op = flash_pkg::FL_WRITE;
                n.cnt    = flash_pkg::WRITE_CYC;
              end
              flash_pkg::CMD_PAGE: begin
                n.req.op = flash_pkg::FL_PAGE;
                n.cnt    = 25'(PAGE_CYC);
              end
              flash_pkg::CMD_PAGE_WRITE: begin
                n.req.op = flash_pkg::FL_PAGE_WRITE;
                n.cnt    = 25'(PW_CYC);
              end
              flash_pkg::CMD_READ: begin
                n.req.op = flash_pkg::FL_READ;
                n.cnt    = flash_pkg::READ_CYC;
              end
              flash_pkg::CMD_ALL: begin
                // write-protected pages are kept; the protection bytes go,
                // which is the only way back to an open part
                n.req.op   = flash_pkg::FL_ALL;
                n.req.keep = we_mask;
                n.cnt      = 25'(ALL_CYC);
              end
              flash_pkg::CMD_PROT: begin
                n.req.op    = flash_pkg::FL_WRITE;
                n.req.addr  = flash_pkg::PROT_BASE;
                // programming can only clear bits of the stored map
                n.req.wdata = prot_src[0] & q.pb[0];
                n.idx       = 3'h0;
                n.seq       = flash_pkg::SQ_PROT;
                n.cnt       = flash_pkg::WRITE_CYC;
              end
              default: begin
                n.req.start = 1'b0;
                n.stat      = flash_pkg::STAT_FAIL;
              end
            endcase
            // protected targets end as a one-cycle no-op
            if (((wdat == flash_pkg::CMD_WRITE) ||
                 (wdat == flash_pkg::CMD_PAGE) ||
                 (wdat == flash_pkg::CMD_PAGE_WRITE)) && pg_we) begin
              n.req.start = 1'b0;
              n.req.op    = flash_pkg::FL_NONE;
              n.cnt       = flash_pkg::ONE_CYC;
              n.stat      = flash_pkg::STAT_FAIL;
            end
            if ((wdat == flash_pkg::CMD_READ) && pg_rd) begin
              n.req.start = 1'b0;
              n.req.op    = flash_pkg::FL_NONE;
              n.cnt       = flash_pkg::ONE_CYC;
              n.stat      = flash_pkg::STAT_FAIL;
            end
            if ((wdat == flash_pkg::CMD_PROT) &&
                (q.dl || !pkey_ok)) begin
              n.req.start = 1'b0;
              n.req.op    = flash_pkg::FL_NONE;
              n.seq       = flash_pkg::SQ_CMD;
              n.cnt       = flash_pkg::ONE_CYC;
              n.stat      = flash_pkg::STAT_FAIL;
            end
          end
          // a refused command must not move the array request: the
          // array may look at the fields at any time, so they stand
          // until the next start pulse
          if (!n.req.start) begin
            n.req       = q.req;
            n.req.start = 1'b0;
          end
        end
      end

      // operation timing; the core is held all the while
      // counts down to one; the final count is the capture cycle
      flash_pkg::ST_RUN: begin
        if (q.cnt > flash_pkg::ONE_CYC) begin
          n.cnt = 25'(q.cnt - flash_pkg::ONE_CYC);
        end else begin
          case (q.seq)
            flash_pkg::SQ_LOAD: begin
              n.pb[q.idx] = i_fl_rdata;
              if (q.idx == flash_pkg::PROT_LAST) begin
                n.idx = 3'h0;
                n.st  = flash_pkg::ST_IDLE;
                // strap is caught once, long after reset release
                n.dl  = ~q.strap_s2;
              end else begin
                n.idx = idx_nx;
                n.st  = flash_pkg::ST_BOOT;
              end
            end
            flash_pkg::SQ_PROT: begin
              if (q.idx == flash_pkg::PROT_LAST) begin
                n.idx = 3'h0;
                n.st  = flash_pkg::ST_IDLE;
              end else begin
                n.idx       = idx_nx;
                n.req.start = 1'b1;
                n.req.addr  = 14'(flash_pkg::PROT_BASE
                                  + 14'(idx_nx));
                n.req.wdata = prot_src[idx_nx] & q.pb[idx_nx];
                n.cnt       = flash_pkg::WRITE_CYC;
              end
            end
            default: begin
              // a refused command keeps the old request, so only an
              // accepted read may load the data register
              if ((q.req.op == flash_pkg::FL_READ) &&
                  (q.stat == flash_pkg::STAT_OK)) begin
                n.edata = i_fl_rdata;
              end
              n.st = flash_pkg::ST_IDLE;
            end
          endcase
        end
      end

      default: begin
        n.st = flash_pkg::ST_BOOT;
      end
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // one struct for all state, so reset reaches every field at once
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q <= flash_pkg::CTL_RST;
    end else begin
      q <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // hold starts in the command cycle itself so no instruction or
  // interrupt slips in; timers elsewhere keep their own clock
  assign o_core_hold = (q.st != flash_pkg::ST_IDLE) |
                       (cmd_wr & (q.st == flash_pkg::ST_IDLE));
  assign o_sfr_rdata     = q.rdata;
  assign o_fl_req        = q.req;
  assign o_download_mode = q.dl;
  assign o_prot_active   = prot_act;

endmodule

`default_nettype wire

// ===== test/flash_protection_and_download_sva.sv
// port-level assertion checker for the flash protection sequencer
`timescale 1ns/1ps
`default_nettype none

module flash_protection_and_download_sva (
  input wire logic                i_clk_sys,
  input wire logic                i_rst,
  input wire flash_pkg::sfr_req_t i_sfr,
  input wire logic [7:0]          o_sfr_rdata,
  input wire flash_pkg::fl_req_t  o_fl_req,
  input wire logic                o_core_hold,
  input wire logic                o_download_mode,
  input wire logic                o_prot_active
);
  // ------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------
  logic        booted_q; // first hold release after reset seen
  logic [15:0] since_q;  // cycles since the last start, saturating

  // boot flag and start age; age saturates so idle time cannot wrap
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      booted_q <= 1'b0;
      since_q  <= 16'hffff;
    end else begin
      booted_q <= booted_q | ~o_core_hold;
      if (o_fl_req.start) begin
        since_q <= 16'h0000;
      end else if (since_q != 16'hffff) begin
        since_q <= since_q + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_start_pulse: assert property (
    o_fl_req.start |=> !o_fl_req.start)
    else $error("start pulse wider than one cycle");
  chk_hold_start: assert property (
    o_fl_req.start |-> o_core_hold)
    else $error("array started without core hold");
  chk_cmd_hold: assert property (
    i_sfr.wr && i_sfr.addr == flash_pkg::A_CMD |-> o_core_hold)
    else $error("command write did not hold core");
  chk_dl_fixed: assert property (
    booted_q |=> $stable(o_download_mode))
    else $error("download mode moved after boot");
  chk_prot_fixed: assert property (
    booted_q |=> $stable(o_prot_active))
    else $error("protection changed without reset");
  chk_rdata_holds: assert property (
    !$past(i_sfr.rd) |-> $stable(o_sfr_rdata))
    else $error("read data moved without a read");
  chk_req_steady: assert property (
    !o_fl_req.start |-> $stable(o_fl_req.op) && $stable(o_fl_req.addr))
    else $error("array request moved between starts");
  // a byte write stalls close to 3750 cycles from its start
  chk_write_time: assert property (
    $fell(o_core_hold) && o_fl_req.op == flash_pkg::FL_WRITE
      && since_q < 16'd3758 |-> since_q >= 16'd3746)
    else $error("byte write ended too early");
endmodule

bind flash_protection_and_download flash_protection_and_download_sva u_sva (
  .i_clk_sys       (i_clk_sys),
  .i_rst           (i_rst),
  .i_sfr           (i_sfr),
  .o_sfr_rdata     (o_sfr_rdata),
  .o_fl_req        (o_fl_req),
  .o_core_hold     (o_core_hold),
  .o_download_mode (o_download_mode),
  .o_prot_active   (o_prot_active)
);

`default_nettype wire

// ===== test/flash_array_model.sv
// behavioural flash array that answers the sequencer's requests
`timescale 1ns/1ps
`default_nettype none

module flash_array_model (
  input  wire logic               i_clk_sys,
  input  wire flash_pkg::fl_req_t i_req,
  output logic [7:0]              o_rdata
);
  logic [7:0]         mem [0:16383]; // array, erased to all ones
  logic [7:0]         last_q;        // last byte on the data lines
  flash_pkg::fl_op_t  op;            // current request kind

  assign op = i_req.op;

  // erased array at power up
  initial begin
    for (int a = 0; a < 16384; a++) begin
      mem[a] = 8'hff;
    end
    last_q = 8'h00;
  end

  // outside reads the lines wander, so stale data is never trusted
  assign o_rdata = (op == flash_pkg::FL_READ) ? mem[i_req.addr] : ~last_q;

  // apply each operation on its start pulse; the later write wins
  always @(posedge i_clk_sys) begin
    last_q <= o_rdata;
    if (i_req.start) begin
      for (int a = 0; a < 16384; a++) begin
        if ((op == flash_pkg::FL_PAGE || op == flash_pkg::FL_PAGE_WRITE)
            && a / 512 == i_req.addr[13:9]) begin
          mem[a] <= 8'hff;
        end
        // pages marked keep survive; protection bytes always go
        if (op == flash_pkg::FL_ALL
            && (!i_req.keep[a / 512] || a >= 16378)) begin
          mem[a] <= 8'hff;
        end
      end
      // programming only clears bits
      if (op == flash_pkg::FL_WRITE) begin
        mem[i_req.addr] <= mem[i_req.addr] & i_req.wdata;
      end else if (op == flash_pkg::FL_PAGE_WRITE) begin
        mem[i_req.addr] <= i_req.wdata;
      end
    end
  end
endmodule

`default_nettype wire

// ===== test/test_flash_protection_and_download.sv
// self-checking bench for the flash protection sequencer
`timescale 1ns/1ps
`default_nettype none

module test_flash_protection_and_download;
  logic                clk = 1'b0; // 125 MHz core clock
  logic                rst;        // async reset, high
  logic                strap_n;    // download strap, low selects
  flash_pkg::sfr_req_t sfr;        // core sfr bus
  flash_pkg::emu_cmd_t emu;        // host emulator commands
  logic [7:0]          fl_rdata;   // array read data
  flash_pkg::fl_req_t  fl_req;     // array request
  logic [7:0]          sfr_rdata;  // sfr read data
  logic                hold;       // core stall
  logic                dl;         // download mode
  logic                prot;       // protection armed
  int                  mismatches = 0;
  int                  checks = 0;
  int                  wc = 3750;  // byte write stall
  int                  rc = 13;    // byte read stall

  always #4 clk = ~clk;

  // short erase counts keep the run brief
  flash_protection_and_download #(
    .PAGE_CYC(20), .PW_CYC(21), .ALL_CYC(40)
  ) u_flash_protection_and_download (
    .i_clk_sys(clk), .i_rst(rst), .i_sfr(sfr), .o_sfr_rdata(sfr_rdata),
    .i_emu(emu), .i_serial_download_strap_n(strap_n),
    .i_fl_rdata(fl_rdata), .o_fl_req(fl_req), .o_core_hold(hold),
    .o_download_mode(dl), .o_prot_active(prot)
  );

  flash_array_model u_flash_array_model (
    .i_clk_sys(clk), .i_req(fl_req), .o_rdata(fl_rdata)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one strobe on the core bus, or with e a host load then store
  task automatic put(input logic [7:0] a, input logic [7:0] d,
                     input logic e);
    if (e) begin
      emu = '{1'b1, flash_pkg::EMU_LOAD, d};
      @(negedge clk);
      emu.valid = 1'b0;
      @(negedge clk);
      emu = '{1'b1, flash_pkg::EMU_STORE, a};
    end else begin
      sfr = '{1'b1, 1'b0, a, d};
    end
    @(negedge clk);
    sfr.wr = 1'b0;
    emu.valid = 1'b0;
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d,
                     input logic e);
    put(a, d, e);
    @(negedge clk);
  endtask

  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    sfr = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    sfr.rd = 1'b0;
    d = sfr_rdata;
    @(negedge clk);
  endtask

  // key, command, bounded wait on the stall, then status
  task automatic run_cmd(input logic [7:0] c, input logic e,
      input logic key, input logic [7:0] st, input int n);
    int k;
    logic [7:0] v;
    if (key) wr8(flash_pkg::A_KEY, flash_pkg::ACCESS_KEY, e);
    put(flash_pkg::A_CMD, c, e);
    k = 0;
    while (hold === 1'b1 && k < 30000) begin
      k++;
      @(negedge clk);
    end
    if (k >= 30000) begin
      mismatches++;
      print_verdict();
    end
    check({31'h0, k >= n && k <= n + 2}, 32'h1);
    rd8(flash_pkg::A_CMD, v);
    check(v, st);
  endtask

  task automatic op_at(input logic [13:0] a, input logic [7:0] c,
      input logic [7:0] d, input logic e, input logic [7:0] st, input int n);
    wr8(flash_pkg::A_DATA, d, e);
    wr8(flash_pkg::A_ADDR_HI, {2'b00, a[13:8]}, e);
    wr8(flash_pkg::A_ADDR_LO, a[7:0], e);
    run_cmd(c, e, 1'b1, st, n);
  endtask

  task automatic rd_fl(input logic [13:0] a, input logic [7:0] st,
                       input logic [7:0] d);
    logic [7:0] v;
    op_at(a, flash_pkg::CMD_READ, 8'h00, 1'b0, st, st == 8'h00 ? rc : 1);
    // a refused read must leave the data register as written
    rd8(flash_pkg::A_DATA, v);
    check(v, d);
  endtask

  task automatic do_reset(input logic s);
    int k;
    strap_n = s;
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    k = 0;
    while (hold !== 1'b0 && k < 200) begin
      k++;
      @(negedge clk);
    end
    if (k >= 200) begin
      mismatches++;
      print_verdict();
    end
  endtask

  // last page write and read protected, default protection key kept
  task automatic prot_regs(input logic e);
    wr8(flash_pkg::A_ADDR_HI, 8'h7f, e);
    wr8(flash_pkg::A_ADDR_LO, 8'hff, e);
    wr8(flash_pkg::A_PB1, 8'hff, e);
    wr8(flash_pkg::A_PB0, 8'hff, e);
    wr8(flash_pkg::A_PRD, 8'h7f, e);
    wr8(flash_pkg::A_PKEY, 8'hff, e);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_ops();
    logic [7:0] v;
    check({hold, dl, prot}, 32'h0);
    op_at(14'h3c00, flash_pkg::CMD_WRITE, 8'hf3, 0, 8'h00, wc);
    rd_fl(14'h3c00, 8'h00, 8'hf3);
    op_at(14'h3c00, flash_pkg::CMD_PAGE_WRITE, 8'h0f, 0, 8'h00, 21);
    rd_fl(14'h3c00, 8'h00, 8'h0f);
    op_at(14'h3c00, flash_pkg::CMD_PAGE, 8'h00, 0, 8'h00, 20);
    rd_fl(14'h3c00, 8'h00, 8'hff);
    run_cmd(flash_pkg::CMD_WRITE, 0, 0, 8'h01, 1);
    run_cmd(8'h07, 0, 1, 8'h01, 1);
    wr8(flash_pkg::A_DATA, 8'h00, 0);
    wr8(flash_pkg::A_DATA, 8'h77, 1);
    rd8(flash_pkg::A_DATA, v);
    check(v, 8'h00);
    rd8(8'h00, v);
    check(v, 8'h00);
  endtask

  task automatic t_protect();
    op_at(14'h3e00, flash_pkg::CMD_WRITE, 8'h5a, 0, 8'h00, wc);
    prot_regs(0);
    run_cmd(flash_pkg::CMD_PROT, 0, 1, 8'h00, 6 * wc);
    check(prot, 1'b0);
    op_at(14'h3e01, flash_pkg::CMD_WRITE, 8'h11, 0, 8'h00, wc);
    do_reset(1'b1);
    check(prot, 1'b1);
    op_at(14'h3e00, flash_pkg::CMD_WRITE, 8'h00, 0, 8'h01, 1);
    op_at(14'h3e00, flash_pkg::CMD_PAGE, 8'h00, 0, 8'h01, 1);
    rd_fl(14'h3e00, 8'h01, 8'h00);
    rd_fl(14'h3fff, 8'h01, 8'h00);
    op_at(14'h0000, flash_pkg::CMD_WRITE, 8'h12, 0, 8'h00, wc);
    rd_fl(14'h0000, 8'h00, 8'h12);
  endtask

  task automatic t_download();
    logic [7:0] v;
    do_reset(1'b0);
    check(dl, 1'b1);
    wr8(flash_pkg::A_DATA, 8'h55, 1);
    rd8(flash_pkg::A_DATA, v);
    check(v, 8'h55);
    prot_regs(1);
    run_cmd(flash_pkg::CMD_PROT, 1, 1, 8'h01, 1);
    op_at(14'h3e00, flash_pkg::CMD_WRITE, 8'h00, 1, 8'h01, 1);
    op_at(14'h0200, flash_pkg::CMD_WRITE, 8'h34, 1, 8'h00, wc);
    rd_fl(14'h0200, 8'h00, 8'h34);
  endtask

  task automatic t_erase_all();
    do_reset(1'b1);
    run_cmd(flash_pkg::CMD_ALL, 0, 1, 8'h00, 40);
    do_reset(1'b1);
    check(prot, 1'b0);
    rd_fl(14'h3e00, 8'h00, 8'h5a);
    rd_fl(14'h0000, 8'h00, 8'hff);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    sfr = '0;
    emu = '0;
    strap_n = 1'b1;
    rst = 1'b1;
    do_reset(1'b1);
    t_ops();
    t_protect();
    t_download();
    t_erase_all();
    print_verdict();
  end
endmodule

`default_nettype wire
